// [include/fsb_defines.svh]
// Timing counts, field positions and register offsets of the shared-bus host.
`ifndef FSB_DEFINES_SVH
`define FSB_DEFINES_SVH
// ==========================================================================
// Timing (clock is 10 MHz, 100 ns period)
`define FSB_CLK_PERIOD_NS 100
`define FSB_RESET_PULSE_MIN_TIME_NS 100
`define FSB_RESET_CYC ((`FSB_RESET_PULSE_MIN_TIME_NS + `FSB_CLK_PERIOD_NS - 1) / `FSB_CLK_PERIOD_NS)
`define FSB_PHASE_CYC 2
// ==========================================================================
// Register offsets (byte addresses)
`define FSB_REG_CTRL 8'h00
`define FSB_REG_ADDR 8'h04
`define FSB_REG_WDATA 8'h08
`define FSB_REG_RDATA 8'h0c
`define FSB_REG_STATUS 8'h10
// ==========================================================================
// Control register fields
`define FSB_CTRL_GO 0
`define FSB_CTRL_WRITE 1
`define FSB_CTRL_RAM 2
`define FSB_CTRL_CE_STROBE 3
`define FSB_CTRL_HIGH_BYTE_N 4
`define FSB_CTRL_LOW_BYTE_N 5
`define FSB_CTRL_RESET 6
`define FSB_CTRL_LOCK_N 7
// Status register fields, then bit positions in the flash status word
`define FSB_STAT_BUSY 0
`define FSB_STAT_POLL 1
`define FSB_STAT_TOGGLE 2
`define FSB_STAT_ERROR 3
`define FSB_STAT_TIMER 4
`define FSB_STAT_CONFLICT 5
`define FSB_POLL_BIT 7
`define FSB_TOGGLE_A_BIT 6
`define FSB_ERROR_BIT 5
`define FSB_TIMER_BIT 3
`define FSB_TOGGLE_B_BIT 2
`endif

// [include/fsb_pkg.sv]
// Types shared by the shared-bus host modules.
package fsb_pkg;
	typedef enum logic [2:0] {
		FSB_IDLE,
		FSB_SETUP,
		FSB_STROBE,
		FSB_RELEASE,
		FSB_RESET
	} fsb_state_e;
	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] wdata;
		logic write;
		logic ram;
		logic ce_strobe;
		logic high_n;
		logic low_n;
	} fsb_req_s;
endpackage : fsb_pkg

// [include/fsb_req_if.sv]
// Request and answer path between the register file and the pin sequencer.
`timescale 1ns/1ps
interface fsb_req_if;
	import fsb_pkg::*;
	fsb_req_s req;
	logic start;
	logic reset_req;
	logic busy;
	logic done;
	logic [15:0] rdata;
	modport regs (output req, output start, output reset_req,
		input busy, input done, input rdata);
	modport seq (input req, input start, input reset_req,
		output busy, output done, output rdata);
endinterface : fsb_req_if

// [src/fsb_pin_seq.sv]
// Pin sequencer that drives one flash or RAM cycle on the shared bus.
`timescale 1ns/1ps
`include "fsb_defines.svh"
module fsb_pin_seq
	import fsb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Request path.
	fsb_req_if.seq rq,
	// Shared bus.
	input wire logic [15:0] dq_i,
	output logic [20:0] addr_o,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	// Strobes.
	output logic flash_select_n_o,
	output logic flash_output_en_n_o,
	output logic flash_write_en_n_o,
	output logic flash_reset_powerdown_n_o,
	output logic ram_select_a_n_o,
	output logic ram_select_b_o,
	output logic ram_output_en_n_o,
	output logic ram_write_en_n_o,
	output logic ram_high_byte_en_n_o,
	output logic ram_low_byte_en_n_o
);
	fsb_state_e state_ff;
	fsb_req_s cur_ff;
	logic [3:0] cnt_ff;
	logic [15:0] rdata_ff;
	logic done_ff;

	assign rq.busy = (state_ff != FSB_IDLE);
	assign rq.done = done_ff;
	assign rq.rdata = rdata_ff;

	// ======================================================================
	// Sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= FSB_IDLE;
			cnt_ff <= 4'h0;
			cur_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				FSB_IDLE: begin
					cnt_ff <= 4'h0;
					if (rq.reset_req) begin
						state_ff <= FSB_RESET;
					end else if (rq.start) begin
						cur_ff <= rq.req;
						state_ff <= FSB_SETUP;
					end
				end
				FSB_SETUP: begin
					state_ff <= FSB_STROBE;
				end
				FSB_STROBE: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == 4'(`FSB_PHASE_CYC - 1)) begin
						cnt_ff <= 4'h0;
						state_ff <= FSB_RELEASE;
					end
				end
				FSB_RELEASE: begin
					done_ff <= 1'b1;
					state_ff <= FSB_IDLE;
				end
				FSB_RESET: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == 4'(`FSB_RESET_CYC)) begin // R12
						done_ff <= 1'b1;
						state_ff <= FSB_IDLE;
					end
				end
				default: state_ff <= FSB_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Pins. Address is stable from setup, so both dies latch a settled value.
	// The strobe falling edge latches the address, its rising edge the data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_o <= 21'h000000;
			dq_o <= 16'h0000;
			dq_oe_o <= 1'b0;
			flash_select_n_o <= 1'b1;
			flash_output_en_n_o <= 1'b1;
			flash_write_en_n_o <= 1'b1;
			flash_reset_powerdown_n_o <= 1'b1;
			ram_select_a_n_o <= 1'b1;
			ram_select_b_o <= 1'b0;
			ram_output_en_n_o <= 1'b1;
			ram_write_en_n_o <= 1'b1;
			ram_high_byte_en_n_o <= 1'b1;
			ram_low_byte_en_n_o <= 1'b1;
			rdata_ff <= 16'h0000;
		end else begin
			flash_reset_powerdown_n_o <= (state_ff != FSB_RESET); // R12
			// Default: both dies deselected so the bus floats.
			flash_select_n_o <= 1'b1; // R8
			ram_select_a_n_o <= 1'b1; // R14
			ram_select_b_o <= 1'b0;
			flash_output_en_n_o <= 1'b1; // R11
			flash_write_en_n_o <= 1'b1;
			ram_output_en_n_o <= 1'b1;
			ram_write_en_n_o <= 1'b1;
			ram_high_byte_en_n_o <= 1'b1;
			ram_low_byte_en_n_o <= 1'b1;
			dq_oe_o <= 1'b0;
			if (state_ff == FSB_SETUP || state_ff == FSB_STROBE) begin
				addr_o <= cur_ff.ram ? {4'h0, cur_ff.addr[16:0]}
					: cur_ff.addr; // R1
				dq_o <= cur_ff.wdata;
				dq_oe_o <= cur_ff.write;
				if (cur_ff.ram) begin
					// Only one die is ever selected at a time.
					ram_high_byte_en_n_o <= cur_ff.high_n; // R18
					ram_low_byte_en_n_o <= cur_ff.low_n; // R18
					ram_select_b_o <= 1'b1;
					ram_select_a_n_o <= cur_ff.ce_strobe && cur_ff.write
						? (state_ff != FSB_STROBE) : 1'b0; // R15 R3
					ram_write_en_n_o <= cur_ff.write
						? (cur_ff.ce_strobe ? 1'b0
						: (state_ff != FSB_STROBE)) : 1'b1; // R16
					ram_output_en_n_o <= cur_ff.write; // R17
				end else begin
					flash_select_n_o <= cur_ff.ce_strobe && cur_ff.write
						? (state_ff != FSB_STROBE) : 1'b0; // R10 R9 R2
					flash_write_en_n_o <= cur_ff.write
						? (cur_ff.ce_strobe ? 1'b0
						: (state_ff != FSB_STROBE)) : 1'b1; // R4
					flash_output_en_n_o <= cur_ff.write; // R5
				end
			end
			// Sample read data at the end of the strobe phase.
			if (state_ff == FSB_STROBE && !cur_ff.write &&
				cnt_ff == 4'(`FSB_PHASE_CYC - 1)) begin
				rdata_ff <= dq_i; // R5 R17
			end
		end
	end
endmodule : fsb_pin_seq

// [src/fsb_host.sv]
// Wishbone-controlled host for a stacked flash and RAM on one shared bus.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "fsb_defines.svh"
// Overview of operation
// R1 - Low seventeen address lines shared; host presents one address per cycle.
// R2 - Flash latches all twenty-one address bits on strobe falling edge.
// R3 - RAM latches address on falling edge of an enable or write strobe.
// R4 - Write data latched on rising edge of the active write strobe.
// R5 - Flash drives reads only with select and output enable low.
// R6 - Data lines float when deselected, disabled, or flash held in reset.
// R7 - Flash status shows poll bit7, toggles 6 and 2, error 5, timer 3.
// R8 - Flash select high deselects flash and floats its outputs.
// R9 - Flash accepts select-strobed writes with write enable held low.
// R10 - Never select flash while RAM is selected.
// R11 - Flash outputs float while its output and write enables are high.
// R12 - Reset pin low for the minimum pulse resets or powers down flash.
// R13 - Lock protect low locks the two parameter blocks; high unlocks them.
// R14 - RAM selected only with first enable low and second high.
// R15 - RAM accepts enable-strobed writes with its write enable held low.
// R16 - RAM write enable low with RAM selected performs the write.
// R17 - RAM output enable low with RAM selected gates read buffers.
// R18 - Byte enables gate upper and lower lanes for reads and writes.
// R19 - Flag whenever both dies would drive the data lines together.
module fsb_host
	import fsb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Shared memory bus.
	input wire logic [15:0] dq_i,
	output logic [20:0] addr_o,
	output logic [15:0] dq_o,
	output logic dq_oe_o,
	// Flash strobes.
	output logic flash_select_n_o,
	output logic flash_output_en_n_o,
	output logic flash_write_en_n_o,
	output logic flash_reset_powerdown_n_o,
	output logic flash_lock_protect_n_o,
	// RAM strobes.
	output logic ram_select_a_n_o,
	output logic ram_select_b_o,
	output logic ram_output_en_n_o,
	output logic ram_write_en_n_o,
	output logic ram_high_byte_en_n_o,
	output logic ram_low_byte_en_n_o
);
	fsb_req_if rq();
	fsb_req_s req_ff;
	logic start_ff;
	logic reset_req_ff;
	logic lock_n_ff;
	logic conflict_ff;
	logic [15:0] rd_ff;
	logic [7:0] ctrl_bits;
	logic wb_hit;

	assign rq.req = req_ff;
	assign rq.start = start_ff;
	assign rq.reset_req = reset_req_ff;
	assign wb_hit = cyc_i && stb_i && !ack_o;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign ctrl_bits = {lock_n_ff, 1'b0, req_ff.low_n, req_ff.high_n,
		req_ff.ce_strobe, req_ff.ram, req_ff.write, 1'b0};

	// ======================================================================
	// Register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_ff <= '{default: '0, high_n: 1'b0, low_n: 1'b0};
			start_ff <= 1'b0;
			reset_req_ff <= 1'b0;
			lock_n_ff <= 1'b0;
		end else begin
			start_ff <= 1'b0;
			reset_req_ff <= 1'b0;
			if (wb_hit && we_i) begin
				case (adr_i)
					`FSB_REG_CTRL: begin
						if (sel_i[0]) begin
							req_ff.write <= dat_i[`FSB_CTRL_WRITE];
							req_ff.ram <= dat_i[`FSB_CTRL_RAM];
							req_ff.ce_strobe <= dat_i[`FSB_CTRL_CE_STROBE];
							req_ff.high_n <= dat_i[`FSB_CTRL_HIGH_BYTE_N];
							req_ff.low_n <= dat_i[`FSB_CTRL_LOW_BYTE_N];
							lock_n_ff <= dat_i[`FSB_CTRL_LOCK_N]; // R13
							// A request while busy is dropped.
							start_ff <= dat_i[`FSB_CTRL_GO] && !rq.busy;
							reset_req_ff <= dat_i[`FSB_CTRL_RESET] &&
								!rq.busy;
						end
					end
					`FSB_REG_ADDR: begin
						req_ff.addr <= 21'(merge({11'h000, req_ff.addr},
							dat_i, sel_i));
					end
					`FSB_REG_WDATA: begin
						req_ff.wdata <= 16'(merge({16'h0000, req_ff.wdata},
							dat_i, sel_i));
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Read data capture and drive-conflict flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ff <= 16'h0000;
			conflict_ff <= 1'b0;
		end else begin
			if (rq.done) begin
				rd_ff <= rq.rdata;
			end
			// Set wins over a clear in the same cycle.
			if (!flash_select_n_o && !flash_output_en_n_o &&
				!ram_select_a_n_o && ram_select_b_o &&
				!ram_output_en_n_o) begin
				conflict_ff <= 1'b1; // R19
			end else if (wb_hit && we_i && adr_i == `FSB_REG_STATUS &&
				sel_i[0] && dat_i[`FSB_STAT_CONFLICT]) begin
				conflict_ff <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Bus answer: one cycle after the request is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= wb_hit;
			dat_o <= 32'h00000000;
			if (wb_hit && !we_i) begin
				case (adr_i)
					`FSB_REG_CTRL: dat_o <= {24'h000000, ctrl_bits};
					`FSB_REG_ADDR: dat_o <= {11'h000, req_ff.addr};
					`FSB_REG_WDATA: dat_o <= {16'h0000, req_ff.wdata};
					`FSB_REG_RDATA: dat_o <= {16'h0000, rd_ff};
					`FSB_REG_STATUS: begin
						// Busy covers the done cycle too, so software never
						// sees idle with the previous word in the bits below.
						dat_o[`FSB_STAT_BUSY] <= rq.busy || rq.done;
						dat_o[`FSB_STAT_POLL] <= rd_ff[`FSB_POLL_BIT]; // R7
						dat_o[`FSB_STAT_TOGGLE] <= rd_ff[`FSB_TOGGLE_A_BIT]
							^ rd_ff[`FSB_TOGGLE_B_BIT]; // R7
						dat_o[`FSB_STAT_ERROR] <= rd_ff[`FSB_ERROR_BIT]; // R7
						dat_o[`FSB_STAT_TIMER] <= rd_ff[`FSB_TIMER_BIT]; // R7
						dat_o[`FSB_STAT_CONFLICT] <= conflict_ff;
					end
					default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_lock_protect_n_o <= 1'b0;
		end else begin
			flash_lock_protect_n_o <= lock_n_ff; // R13
		end
	end

	// The sequencer releases dq_oe_o in every idle cycle so the bus floats.
	fsb_pin_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rq(rq.seq),
		.dq_i(dq_i),
		.addr_o(addr_o),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_o), // R6
		.flash_select_n_o(flash_select_n_o),
		.flash_output_en_n_o(flash_output_en_n_o),
		.flash_write_en_n_o(flash_write_en_n_o),
		.flash_reset_powerdown_n_o(flash_reset_powerdown_n_o),
		.ram_select_a_n_o(ram_select_a_n_o),
		.ram_select_b_o(ram_select_b_o),
		.ram_output_en_n_o(ram_output_en_n_o),
		.ram_write_en_n_o(ram_write_en_n_o),
		.ram_high_byte_en_n_o(ram_high_byte_en_n_o),
		.ram_low_byte_en_n_o(ram_low_byte_en_n_o)
	);
endmodule : fsb_host

// [test/fsb_host_checker.sv]
// Pin-level assertions for the shared-bus host.
`timescale 1ns/1ps
module fsb_host_checker (
	// Clock, reset and bus handshake.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Shared memory bus.
	input wire logic [20:0] addr_o,
	input wire logic [15:0] dq_o,
	input wire logic dq_oe_o,
	// Strobes.
	input wire logic flash_select_n_o,
	input wire logic flash_output_en_n_o,
	input wire logic flash_write_en_n_o,
	input wire logic flash_reset_powerdown_n_o,
	input wire logic ram_select_a_n_o,
	input wire logic ram_select_b_o,
	input wire logic ram_output_en_n_o,
	input wire logic ram_write_en_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire ram_on = !ram_select_a_n_o && ram_select_b_o;
	// ========
	// Assertions
	dies_exclusive_a: assert property (!(!flash_select_n_o && ram_on))
		else $error("flash and ram selected together");
	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_prompt_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack not one cycle after request");
	flash_read_a: assert property (!flash_output_en_n_o |->
		!dq_oe_o && flash_write_en_n_o) else $error("flash read clash");
	ram_read_a: assert property (!ram_output_en_n_o |->
		!dq_oe_o && ram_write_en_n_o) else $error("ram read clash");
	ram_write_data_a: assert property (!ram_write_en_n_o && ram_on |-> dq_oe_o)
		else $error("ram write without data");
	write_hold_a: assert property (!flash_write_en_n_o &&
		$past(!flash_write_en_n_o) |-> $stable(addr_o) && $stable(dq_o))
		else $error("address or data moved in flash write");
	ram_high_zero_a: assert property (ram_on |-> addr_o[20:17] == 4'h0)
		else $error("flash-only address bits set on ram cycle");
	reset_width_a: assert property ($fell(flash_reset_powerdown_n_o) |=>
		!flash_reset_powerdown_n_o) else $error("reset pulse too short");
	cover property (ram_on && !ram_write_en_n_o);
	cover property (!flash_select_n_o && !flash_output_en_n_o);
	cover property ($fell(flash_reset_powerdown_n_o));
endmodule : fsb_host_checker
bind fsb_host fsb_host_checker u_fsb_host_checker (.clk_i, .rst_i, .cyc_i,
	.stb_i, .ack_o, .addr_o, .dq_o, .dq_oe_o, .flash_select_n_o,
	.flash_output_en_n_o, .flash_write_en_n_o, .flash_reset_powerdown_n_o,
	.ram_select_a_n_o, .ram_select_b_o, .ram_output_en_n_o,
	.ram_write_en_n_o);

// [test/fsb_mem_model.sv]
// Behavioural model of the stacked flash and RAM dies on the shared bus.
`timescale 1ns/1ps
module fsb_mem_model #(
	parameter int LOCK_TOP = 8'hff,
	parameter int RESET_MIN_NS = 100
) (
	// Shared bus.
	input wire logic [20:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	// Flash pins.
	input wire logic flash_select_n_i,
	input wire logic flash_output_en_n_i,
	input wire logic flash_write_en_n_i,
	input wire logic flash_reset_powerdown_n_i,
	input wire logic flash_lock_protect_n_i,
	// RAM pins.
	input wire logic ram_select_a_n_i,
	input wire logic ram_select_b_i,
	input wire logic ram_output_en_n_i,
	input wire logic ram_write_en_n_i,
	input wire logic ram_high_byte_en_n_i,
	input wire logic ram_low_byte_en_n_i,
	// Observations.
	output logic clash_o = 1'b0,
	output int resets_o = 0
);
	logic [15:0] fmem [int];
	logic [15:0] rmem [int];
	// Start at zero so power-up strobe edges never index with unknowns.
	logic [20:0] fa = 21'h0;
	logic [16:0] ra = 17'h0;
	logic [15:0] mv;
	logic [15:0] held = 16'h0;
	realtime t_low = 1.0e9;
	// Delayed copies: the host may release data and strobes on one edge.
	wire [15:0] #1 dqd = dq_i;
	wire [1:0] #1 bed = {ram_high_byte_en_n_i, ram_low_byte_en_n_i};
	wire r_on = !ram_select_a_n_i && ram_select_b_i;
	wire f_wr = !flash_select_n_i && !flash_write_en_n_i;
	wire r_wr = r_on && !ram_write_en_n_i;
	wire f_drv = !flash_select_n_i && !flash_output_en_n_i &&
		flash_reset_powerdown_n_i;
	wire r_drv = r_on && !ram_output_en_n_i;
	// ========
	// Writes
	always @(posedge f_wr) #1 fa = addr_i;
	always @(negedge f_wr)
		if (flash_lock_protect_n_i || fa[20:13] != LOCK_TOP) fmem[fa] = dqd;
	always @(posedge r_wr) #1 ra = addr_i[16:0];
	always @(negedge r_wr) begin
		if (!rmem.exists(ra)) rmem[ra] = 16'h0;
		if (!bed[1]) rmem[ra][15:8] = dqd[15:8];
		if (!bed[0]) rmem[ra][7:0] = dqd[7:0];
	end
	// ========
	// Reads: released lines show the inverse of the last driven word.
	always @* begin
		if (r_drv) mv = rmem.exists(addr_i[16:0]) ? rmem[addr_i[16:0]] : 16'h0;
		else mv = fmem.exists(addr_i) ? fmem[addr_i] : 16'hffff;
		if (f_drv || r_drv) held = mv;
		dq_o = ~held;
		if (f_drv) dq_o = mv;
		if (r_drv && !ram_high_byte_en_n_i) dq_o[15:8] = mv[15:8];
		if (r_drv && !ram_low_byte_en_n_i) dq_o[7:0] = mv[7:0];
		if (f_drv && r_drv) clash_o = 1'b1;
	end
	always @(negedge flash_reset_powerdown_n_i) t_low = $realtime;
	always @(posedge flash_reset_powerdown_n_i)
		if ($realtime - t_low >= RESET_MIN_NS) resets_o++;
endmodule : fsb_mem_model

// [test/fsb_host_tb_top.sv]
// Self-checking bench for the shared-bus host against a memory model.
`timescale 1ns/1ps
`include "fsb_defines.svh"
module fsb_host_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd, st;
	logic ack_o, dq_oe_o, clash;
	logic [15:0] dq_i, dq_o;
	logic [20:0] addr_o;
	logic flash_select_n_o, flash_output_en_n_o, flash_write_en_n_o;
	logic flash_reset_powerdown_n_o, flash_lock_protect_n_o;
	logic ram_select_a_n_o, ram_select_b_o, ram_output_en_n_o;
	logic ram_write_en_n_o, ram_high_byte_en_n_o, ram_low_byte_en_n_o;
	int errors = 0, comparisons = 0, seed = 57, resets;
	int ram_ref [int];
	int flash_ref [int];
	fsb_host u_fsb_host (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .dq_i, .addr_o, .dq_o, .dq_oe_o,
		.flash_select_n_o, .flash_output_en_n_o, .flash_write_en_n_o,
		.flash_reset_powerdown_n_o, .flash_lock_protect_n_o,
		.ram_select_a_n_o, .ram_select_b_o, .ram_output_en_n_o,
		.ram_write_en_n_o, .ram_high_byte_en_n_o, .ram_low_byte_en_n_o);
	fsb_mem_model u_fsb_mem_model (.addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i),
		.flash_select_n_i(flash_select_n_o),
		.flash_output_en_n_i(flash_output_en_n_o),
		.flash_write_en_n_i(flash_write_en_n_o),
		.flash_reset_powerdown_n_i(flash_reset_powerdown_n_o),
		.flash_lock_protect_n_i(flash_lock_protect_n_o),
		.ram_select_a_n_i(ram_select_a_n_o), .ram_select_b_i(ram_select_b_o),
		.ram_output_en_n_i(ram_output_en_n_o),
		.ram_write_en_n_i(ram_write_en_n_o),
		.ram_high_byte_en_n_i(ram_high_byte_en_n_o),
		.ram_low_byte_en_n_i(ram_low_byte_en_n_o), .clash_o(clash),
		.resets_o(resets));
	// ========
	// Tasks
	task automatic check(input string what, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic results();
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
		if (n == 20) errors++;
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	// Leaves the final status word in rd once the host is idle again.
	task automatic op(input logic [7:0] c, input logic [20:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		wb(1'b1, `FSB_REG_ADDR, {11'h0, a});
		wb(1'b1, `FSB_REG_WDATA, {16'h0, d});
		wb(1'b1, `FSB_REG_CTRL, {24'h0, c});
		do wb(1'b0, `FSB_REG_STATUS, 32'h0);
		while (rd[`FSB_STAT_BUSY] !== 1'b0 && ++n < 50);
		if (n == 50) errors++;
	endtask : op
	// ========
	// Sequence
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#(5000 * 100);
		errors++;
		results();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h14, 32'h0);
		check("unmapped", 32'h0, rd);
		for (int i = 0; i < 16; i++) begin
			logic [20:0] a;
			logic [15:0] d, e;
			logic [3:0] m;
			int k;
			a = $random(seed);
			d = $random(seed);
			m = $random(seed);
			if (m[0]) a[20:17] = 4'h0;
			op({2'b10, m, 2'b11}, a, d);
			if (m[0]) begin
				k = ram_ref.exists(a) ? ram_ref[a] : 0;
				if (!m[2]) k[15:8] = d[15:8];
				if (!m[3]) k[7:0] = d[7:0];
				ram_ref[a] = k;
			end else flash_ref[a] = d;
			op({5'b10000, m[0], 2'b01}, a, 16'h0);
			st = rd;
			wb(1'b0, `FSB_REG_RDATA, 32'h0);
			e = m[0] ? ram_ref[a] : flash_ref[a];
			check("rdata", e, rd[15:0]);
			if (!m[0]) check("status", {e[3], e[5], e[6] ^ e[2], e[7]}, st[4:1]);
		end
		for (int l = 0; l < 2; l++) begin
			op({l[0], 7'h03}, 21'h1fe005, 16'h1234 + l);
			op(8'h81, 21'h1fe005, 16'h0);
			wb(1'b0, `FSB_REG_RDATA, 32'h0);
			check("locked", l ? 32'h1235 : 32'hffff, rd[15:0]);
		end
		op(8'hc0, 21'h0, 16'h0);
		op(8'h81, 21'h1fe005, 16'h0);
		wb(1'b0, `FSB_REG_RDATA, 32'h0);
		check("resets", 32'h1, resets);
		check("kept", 32'h1235, rd[15:0]);
		check("clash", 32'h0, clash);
		results();
	end
endmodule : fsb_host_tb_top
